// ==== rtl/ssag_pkg.sv ====
// Purpose: Constants and types for the strap sampling and address gate block
// Assumes: 100 MHz clk; Avalon-MM slave with byte addresses
// Notes: All offsets, fields, reset values and counts live here
package ssag_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
    localparam int XFER_NS = 40;
    // Least time, so round up
    localparam int XFER_CYC = (XFER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] XFER_LAST = 4'(XFER_CYC - 1);
    // Three sync stages plus one filter stage before straps are trusted
    localparam logic [3:0] STRAP_CYC = 4'h4;

    // ----------------------------------------------------------------
    // Register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [4:0] OFS_GATE = 5'h00;
    localparam logic [4:0] OFS_CHAN = 5'h04;
    localparam logic [4:0] OFS_STRAP = 5'h08;
    localparam logic [4:0] OFS_DMA = 5'h0C;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
    localparam logic [4:0] OFS_PINS = 5'h18;

    // ----------------------------------------------------------------
    // Fields
    // ----------------------------------------------------------------
    localparam int ALT_GATE_BIT = 1;
    localparam int SW_RST_BIT = 7;
    localparam int STRAP_SPD_LSB = 0;
    localparam int STRAP_WIDE_BIT = 2;
    localparam int STRAP_MHZ_LSB = 8;
    localparam int STRAP_DONE_BIT = 16;
    localparam int DMA_START_BIT = 0;
    localparam int DMA_CNT_LSB = 8;
    localparam int IRQ_W = 3;
    localparam int IRQ_CHK_BIT = 0;
    localparam int IRQ_CMD_BIT = 1;
    localparam int IRQ_DONE_BIT = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic RST_ALT_GATE = 1'b0;
    localparam logic RST_SW_RST = 1'b0;
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;

    // ----------------------------------------------------------------
    // Synchroniser lanes
    // ----------------------------------------------------------------
    localparam int NSYNC = 8;
    localparam int SY_GREQ = 0;
    localparam int SY_MSTR = 1;
    localparam int SY_GPIN = 2;
    localparam int SY_APIN = 3;
    localparam int SY_CHK = 4;
    localparam int SY_CMD = 5;
    localparam int SY_BURST = 6;
    localparam int SY_CPU = 7;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SPD_16 = 2'h0, SPD_20 = 2'h1, SPD_25 = 2'h2, SPD_33 = 2'h3}
        ssag_speed_t;
    localparam logic [7:0] MHZ_16 = 8'h10;
    localparam logic [7:0] MHZ_20 = 8'h14;
    localparam logic [7:0] MHZ_25 = 8'h19;
    localparam logic [7:0] MHZ_33 = 8'h21;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ACK = 2'b01, ST_DONE = 2'b11} ssag_state_t;
endpackage : ssag_pkg

// ==== rtl/ssag_sync3.sv ====
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Input is asynchronous to clk
// Notes: Output moves only when stages two and three agree
`timescale 1ns/10ps
module ssag_sync3
(
    input wire logic clk, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic pinIn, // Raw pin level
    output logic syncOut // Filtered level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // First stage feeds only the second one
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Take a change once two settled stages agree
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            syncOut <= 1'b0;
        else if (s2_q == s3_q)
            syncOut <= s3_q;
    end
endmodule : ssag_sync3

// ==== rtl/ssag_top.sv ====
// Purpose: Speed and bus straps, address bit 20 gate, channel reset, acknowledge
// Assumes: Single 100 MHz clock; Avalon-MM slave, one wait state per access
// Notes: Pins stay undriven until straps are latched after reset release
`timescale 1ns/10ps
module ssag_top
(
    input wire logic clk, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic [4:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Wait, high holds master
    input wire logic addr_gate_request_in, // Gate request from keyboard controller
    input wire logic channel_master_strap, // Speed strap column pin
    input wire logic cpu_owns_bus, // Processor holds the bus
    input wire logic channel_error_check, // High on serious error
    input wire logic channel_command_any, // Any channel command active
    input wire logic burst_in, // Burst permitted
    input wire logic addr_bit20_gate_in, // Gate pin level
    output logic addr_bit20_gate_out, // Gate pin drive value
    output logic addr_bit20_gate_oe, // Gate pin enable
    input wire logic dma_acknowledge_pin_in, // Acknowledge pin level
    output logic dma_acknowledge_pin_out, // Acknowledge drive value
    output logic dma_acknowledge_pin_oe, // Acknowledge pin enable
    output logic channel_reset_out, // Channel reset, active high
    output logic irq // Level interrupt
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [ssag_pkg::NSYNC-1:0] rawIn;
    logic [ssag_pkg::NSYNC-1:0] syn;
    assign rawIn = {cpu_owns_bus, burst_in, channel_command_any, channel_error_check,
                    dma_acknowledge_pin_in, addr_bit20_gate_in, channel_master_strap,
                    addr_gate_request_in};

    // One filtered synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < ssag_pkg::NSYNC; gi++)
        begin : g_sync
            ssag_sync3 u_sync
            (
                .clk(clk),
                .rstn(rstn),
                .pinIn(rawIn[gi]),
                .syncOut(syn[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    logic [3:0] strapCnt_q;
    logic strapDone_q;
    ssag_pkg::ssag_speed_t speed_q;
    logic fullWidth_q;

    function automatic ssag_pkg::ssag_speed_t spdCode(input logic mstr, input logic gate);
        ssag_pkg::ssag_speed_t s;
        s = ssag_pkg::SPD_16;
        unique case ({mstr, gate})
            2'b00: s = ssag_pkg::SPD_16;
            2'b01: s = ssag_pkg::SPD_20;
            2'b11: s = ssag_pkg::SPD_25;
            2'b10: s = ssag_pkg::SPD_33;
        endcase
        return s;
    endfunction : spdCode

    // Wait for the synchronisers to fill, then latch once and hold
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            strapCnt_q <= 4'h0;
            strapDone_q <= 1'b0;
            speed_q <= ssag_pkg::SPD_16;
            fullWidth_q <= 1'b0;
        end
        else if (!strapDone_q)
        begin
            if (strapCnt_q == ssag_pkg::STRAP_CYC)
            begin
                strapDone_q <= 1'b1;
                speed_q <= spdCode(syn[ssag_pkg::SY_MSTR], syn[ssag_pkg::SY_GPIN]);
                fullWidth_q <= syn[ssag_pkg::SY_APIN];
            end
            else
                strapCnt_q <= 4'(strapCnt_q + 4'h1);
        end
    end

    logic [7:0] speedMhz;
    // Frequency shown to software
    always_comb
    begin
        speedMhz = ssag_pkg::MHZ_16;
        unique case (speed_q)
            ssag_pkg::SPD_16: speedMhz = ssag_pkg::MHZ_16;
            ssag_pkg::SPD_20: speedMhz = ssag_pkg::MHZ_20;
            ssag_pkg::SPD_25: speedMhz = ssag_pkg::MHZ_25;
            ssag_pkg::SPD_33: speedMhz = ssag_pkg::MHZ_33;
        endcase
    end

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic wait_q;
    logic [31:0] rdata_q;
    logic altGate_q;
    logic swRst_q;
    logic [ssag_pkg::IRQ_W-1:0] irqStat_q;
    logic [ssag_pkg::IRQ_W-1:0] irqMask_q;
    logic [7:0] remain_q;
    ssag_pkg::ssag_state_t state_q;
    logic [31:0] beMask;
    logic [31:0] wdat;
    logic wrTake;
    logic [31:0] rdMux;

    assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wdat = avs_writedata & beMask;
    assign wrTake = avs_write && !wait_q;

    // Wait low for one cycle after each request cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            wait_q <= 1'b1;
        else if (!wait_q)
            wait_q <= 1'b1;
        else if (avs_read || avs_write)
            wait_q <= 1'b0;
    end

    // Read mux; unmapped offsets read as zero
    always_comb
    begin
        rdMux = 32'h0000_0000;
        unique case (avs_address)
            ssag_pkg::OFS_GATE: rdMux[ssag_pkg::ALT_GATE_BIT] = altGate_q;
            ssag_pkg::OFS_CHAN: rdMux[ssag_pkg::SW_RST_BIT] = swRst_q;
            ssag_pkg::OFS_STRAP:
            begin
                rdMux[ssag_pkg::STRAP_SPD_LSB +: 2] = speed_q;
                rdMux[ssag_pkg::STRAP_WIDE_BIT] = fullWidth_q;
                rdMux[ssag_pkg::STRAP_MHZ_LSB +: 8] = speedMhz;
                rdMux[ssag_pkg::STRAP_DONE_BIT] = strapDone_q;
            end
            ssag_pkg::OFS_DMA:
            begin
                rdMux[ssag_pkg::DMA_START_BIT] = (state_q != ssag_pkg::ST_IDLE);
                rdMux[ssag_pkg::DMA_CNT_LSB +: 8] = remain_q;
            end
            ssag_pkg::OFS_IRQ_STAT: rdMux[ssag_pkg::IRQ_W-1:0] = irqStat_q;
            ssag_pkg::OFS_IRQ_MASK: rdMux[ssag_pkg::IRQ_W-1:0] = irqMask_q;
            ssag_pkg::OFS_PINS: rdMux[ssag_pkg::NSYNC-1:0] = syn;
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // Data is registered so it stands at the edge wait drops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata_q <= 32'h0000_0000;
        else if (avs_read && wait_q)
            rdata_q <= rdMux;
    end

    // Control bits
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            altGate_q <= ssag_pkg::RST_ALT_GATE;
            swRst_q <= ssag_pkg::RST_SW_RST;
            irqMask_q <= ssag_pkg::RST_IRQ_MASK;
        end
        else if (wrTake)
        begin
            if (avs_address == ssag_pkg::OFS_GATE && avs_byteenable[0])
                altGate_q <= wdat[ssag_pkg::ALT_GATE_BIT];
            if (avs_address == ssag_pkg::OFS_CHAN && avs_byteenable[0])
                swRst_q <= wdat[ssag_pkg::SW_RST_BIT];
            if (avs_address == ssag_pkg::OFS_IRQ_MASK && avs_byteenable[0])
                irqMask_q <= wdat[ssag_pkg::IRQ_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Gate and channel reset
    // ----------------------------------------------------------------
    logic gateWant;
    assign gateWant = syn[ssag_pkg::SY_GREQ] || (altGate_q && syn[ssag_pkg::SY_CPU]);

    // Pin stays released during strap capture so straps are not fought
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            addr_bit20_gate_out <= 1'b0;
            addr_bit20_gate_oe <= 1'b0;
        end
        else
        begin
            addr_bit20_gate_out <= strapDone_q && gateWant;
            addr_bit20_gate_oe <= strapDone_q;
        end
    end

    // Held from power-on until straps settle, then by software
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            channel_reset_out <= 1'b1;
        else
            channel_reset_out <= !strapDone_q || swRst_q;
    end

    // ----------------------------------------------------------------
    // Acknowledge sequencer
    // ----------------------------------------------------------------
    logic [3:0] xferCnt_q;
    logic startReq;
    logic xferEnd;
    assign startReq = wrTake && avs_address == ssag_pkg::OFS_DMA && avs_byteenable[0]
                      && wdat[ssag_pkg::DMA_START_BIT] && strapDone_q;
    assign xferEnd = state_q == ssag_pkg::ST_ACK && xferCnt_q == ssag_pkg::XFER_LAST;

    // Each acknowledge covers one transfer unless burst holds it on
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= ssag_pkg::ST_IDLE;
            xferCnt_q <= 4'h0;
            remain_q <= 8'h00;
            dma_acknowledge_pin_out <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ssag_pkg::ST_IDLE:
                    if (startReq)
                    begin
                        state_q <= ssag_pkg::ST_ACK;
                        xferCnt_q <= 4'h0;
                        remain_q <= avs_byteenable[1] ? wdat[ssag_pkg::DMA_CNT_LSB +: 8] : 8'h00;
                        dma_acknowledge_pin_out <= 1'b1;
                    end
                ssag_pkg::ST_ACK:
                    if (!xferEnd)
                        xferCnt_q <= 4'(xferCnt_q + 4'h1);
                    else if (syn[ssag_pkg::SY_BURST] && remain_q != 8'h00)
                    begin
                        xferCnt_q <= 4'h0;
                        remain_q <= 8'(remain_q - 8'h01);
                    end
                    else
                    begin
                        state_q <= ssag_pkg::ST_DONE;
                        dma_acknowledge_pin_out <= 1'b0;
                    end
                ssag_pkg::ST_DONE: state_q <= ssag_pkg::ST_IDLE;
                default:
                begin
                    state_q <= ssag_pkg::ST_IDLE;
                    dma_acknowledge_pin_out <= 1'b0;
                end
            endcase
        end
    end

    // Driven as output once the strap is latched
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            dma_acknowledge_pin_oe <= 1'b0;
        else
            dma_acknowledge_pin_oe <= strapDone_q;
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    logic chkPrev_q;
    logic cmdPrev_q;
    logic [ssag_pkg::IRQ_W-1:0] evt;
    logic [ssag_pkg::IRQ_W-1:0] clr;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            chkPrev_q <= 1'b0;
            cmdPrev_q <= 1'b0;
        end
        else
        begin
            chkPrev_q <= syn[ssag_pkg::SY_CHK];
            cmdPrev_q <= syn[ssag_pkg::SY_CMD];
        end
    end
    assign evt[ssag_pkg::IRQ_CHK_BIT] = syn[ssag_pkg::SY_CHK] && !chkPrev_q;
    assign evt[ssag_pkg::IRQ_CMD_BIT] = syn[ssag_pkg::SY_CMD] && !cmdPrev_q;
    assign evt[ssag_pkg::IRQ_DONE_BIT] = xferEnd && state_q == ssag_pkg::ST_ACK
                                         && !(syn[ssag_pkg::SY_BURST] && remain_q != 8'h00);
    assign clr = (wrTake && avs_address == ssag_pkg::OFS_IRQ_STAT && avs_byteenable[0])
                 ? wdat[ssag_pkg::IRQ_W-1:0] : 3'h0;

    // Sticky; a new event beats a clear in the same cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irqStat_q <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            irqStat_q <= (irqStat_q & ~clr) | evt;
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    speed_decode_a: assert property ($rose(strapDone_q) |->
        speed_q == spdCode($past(syn[ssag_pkg::SY_MSTR]), $past(syn[ssag_pkg::SY_GPIN])))
        else $error("speed strap decode wrong");
    gate_drive_a: assert property (strapDone_q && gateWant |=> addr_bit20_gate_out)
        else $error("gate not driven");
    gate_idle_a: assert property (!(strapDone_q && gateWant) |=> !addr_bit20_gate_out)
        else $error("gate active without cause");
    chan_rst_por_a: assert property (!strapDone_q |=> channel_reset_out &&
        !addr_bit20_gate_oe) else $error("channel reset missing at power-on");
    chan_rst_sw_a: assert property (strapDone_q && swRst_q |=> channel_reset_out)
        else $error("software channel reset missing");
    bus_mode_hold_a: assert property (strapDone_q && $past(strapDone_q) |->
        $stable(fullWidth_q)) else $error("bus mode changed");
    ack_len_a: assert property ($rose(dma_acknowledge_pin_out) |->
        dma_acknowledge_pin_out [*4]) else $error("acknowledge shorter than one transfer");
    ack_single_a: assert property (xferEnd && !syn[ssag_pkg::SY_BURST] |=>
        !dma_acknowledge_pin_out)
        else $error("acknowledge held without burst");
    chk_flag_a: assert property (evt[ssag_pkg::IRQ_CHK_BIT] |=>
        irqStat_q[ssag_pkg::IRQ_CHK_BIT]) else $error("channel check not flagged");
    irq_level_a: assert property (|(irqStat_q & irqMask_q) |=> irq)
        else $error("interrupt not raised");
    bus_answer_a: assert property ((avs_read || avs_write) && wait_q |=> !wait_q)
        else $error("bus answer late");

    strap_c: cover property ($rose(strapDone_q));
    burst_c: cover property (xferEnd && syn[ssag_pkg::SY_BURST] && remain_q != 8'h00);
    irq_c: cover property ($rose(irq));
endmodule : ssag_top

// ==== testbench/ssag_far_model.sv ====
// Purpose: Far side of the pins: straps, gate and acknowledge pin levels, channel lines
// Assumes: Straps are driven only while the block leaves its two-way pins undriven
// Notes: Wire level is resolved here from the block's drive enables, drive values and strap levels
`timescale 1ns/10ps
module ssag_far_model
(
    input wire logic gateStrap, // Level pulled onto gate pin while undriven
    input wire logic ackStrap, // Level pulled onto acknowledge pin while undriven
    input wire logic gateOut, // Block drive value
    input wire logic gateOe, // Block drive enable
    input wire logic ackOut, // Block drive value
    input wire logic ackOe, // Block drive enable
    input wire logic cmdStrobe, // Plain command strobe
    input wire logic memCmd, // Matched memory command strobe
    input wire logic errIn, // Adapter reports a serious error
    output logic gatePin, // Resolved gate pin
    output logic ackPin, // Resolved acknowledge pin
    output logic cmdAny, // Combined command line
    output logic chkLine // Channel check line
);
    // ----------------------------------------------------------------
    // Pin resolution
    // ----------------------------------------------------------------
    // Strap resistors win only while the block is not driving
    assign gatePin = gateOe ? gateOut : gateStrap;
    assign ackPin = ackOe ? ackOut : ackStrap;
    // Glue OR of both strobes, so any command shows
    assign cmdAny = cmdStrobe | memCmd;
    assign chkLine = errIn;
endmodule : ssag_far_model

// ==== testbench/ssag_top_tb.sv ====
// Purpose: Self-checking bench for straps, gate, channel reset, acknowledge, irq
// Assumes: Avalon master holds each request until waitrequest is sampled low
// Notes: Sync chains need about four cycles, so pin changes are given eight
`timescale 1ns/10ps
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin badCount++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module ssag_top_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, gateOut, gateOe, ackOut, ackOe, chanRst, irq;
    logic greq = 1'b0, mstr = 1'b0, cpuOwns = 1'b0, burst = 1'b0;
    logic cmdStrobe = 1'b0, memCmd = 1'b0, errIn = 1'b0, gateStrap = 1'b0, ackStrap = 1'b0;
    logic gatePin, ackPin, cmdAny, chkLine;
    logic [31:0] rd;
    logic [7:0] mhz [4] = '{ssag_pkg::MHZ_16, ssag_pkg::MHZ_20,
        ssag_pkg::MHZ_25, ssag_pkg::MHZ_33};
    int badCount = 0;
    int testsRun = 0;
    int cycles = 0;

    // ----------------------------------------------------------------
    // Clock, instances, hang guard
    // ----------------------------------------------------------------
    always #5 clk = ~clk;
    ssag_top dut_u (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .addr_gate_request_in(greq), .channel_master_strap(mstr), .cpu_owns_bus(cpuOwns),
        .channel_error_check(chkLine), .channel_command_any(cmdAny), .burst_in(burst),
        .addr_bit20_gate_in(gatePin), .addr_bit20_gate_out(gateOut), .addr_bit20_gate_oe(gateOe),
        .dma_acknowledge_pin_in(ackPin), .dma_acknowledge_pin_out(ackOut),
        .dma_acknowledge_pin_oe(ackOe), .channel_reset_out(chanRst), .irq(irq));
    ssag_far_model far_u (.gateStrap(gateStrap), .ackStrap(ackStrap), .gateOut(gateOut),
        .gateOe(gateOe), .ackOut(ackOut), .ackOe(ackOe), .cmdStrobe(cmdStrobe), .memCmd(memCmd),
        .errIn(errIn), .gatePin(gatePin), .ackPin(ackPin), .cmdAny(cmdAny), .chkLine(chkLine));
    // Whole run is about 320 cycles; ceiling leaves ample slack
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            badCount++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // Request held until waitrequest is sampled low, data taken at that edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // Reset with given straps, then read the latched decode
    task automatic strap(input logic m, input logic g, input logic a);
        rstn <= 1'b0;
        mstr <= m;
        gateStrap <= g;
        ackStrap <= a;
        repeat (2) @(posedge clk);
        `CHK("chanRstInReset", 1'b1, chanRst)
        `CHK("oeInReset", 2'b00, {gateOe, ackOe})
        rstn <= 1'b1;
        repeat (12) @(posedge clk);
        bus(1'b0, ssag_pkg::OFS_STRAP, 32'h0);
        `CHK("speed", {m, m ^ g}, rd[1:0])
        `CHK("mhz", mhz[{m, m ^ g}], rd[15:8])
        `CHK("width", a, rd[2])
        `CHK("done", 1'b1, rd[16])
        `CHK("chanRstAfter", 1'b0, chanRst)
        `CHK("oeAfter", 2'b11, {gateOe, ackOe})
    endtask : strap

    task automatic gate_test();
        greq <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("gateReq", 1'b1, gateOut)
        greq <= 1'b0;
        cpuOwns <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("gateIdle", 1'b0, gateOut)
        bus(1'b1, ssag_pkg::OFS_GATE, 32'h2);
        repeat (3) @(posedge clk);
        `CHK("gateAlt", 1'b1, gateOut)
        bus(1'b0, ssag_pkg::OFS_GATE, 32'h0);
        `CHK("altBack", 32'h0000_0002, rd)
        cpuOwns <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK("gateAltNoCpu", 1'b0, gateOut)
        bus(1'b1, ssag_pkg::OFS_GATE, 32'h0);
    endtask : gate_test

    task automatic swrst_test();
        // Lane 0 disabled: the software reset bit must not move
        avs_byteenable <= 4'hE;
        bus(1'b1, ssag_pkg::OFS_CHAN, 32'h80);
        avs_byteenable <= 4'hF;
        repeat (2) @(posedge clk);
        `CHK("laneOff", 1'b0, chanRst)
        bus(1'b1, ssag_pkg::OFS_CHAN, 32'h80);
        repeat (2) @(posedge clk);
        `CHK("swRstOn", 1'b1, chanRst)
        bus(1'b1, ssag_pkg::OFS_CHAN, 32'h0);
        repeat (2) @(posedge clk);
        `CHK("swRstOff", 1'b0, chanRst)
        bus(1'b0, 5'h1C, 32'h0);
        `CHK("unmapped", 32'h0, rd)
    endtask : swrst_test

    // Counts acknowledge-high cycles after one start
    task automatic dma_test(input logic b, input logic [7:0] n, input int exp);
        int cnt;
        cnt = 0;
        burst <= b;
        repeat (8) @(posedge clk);
        bus(1'b1, ssag_pkg::OFS_DMA, {16'h0, n, 8'h01});
        repeat (40)
        begin
            @(posedge clk);
            if (ackOut === 1'b1)
                cnt++;
        end
        `CHK("ackCycles", exp, cnt)
    endtask : dma_test

    task automatic irq_test();
        bus(1'b0, ssag_pkg::OFS_IRQ_STAT, 32'h0);
        `CHK("doneEvent", 1'b1, rd[2])
        bus(1'b1, ssag_pkg::OFS_IRQ_STAT, 32'h7);
        errIn <= 1'b1;
        cmdStrobe <= 1'b1;
        repeat (8) @(posedge clk);
        bus(1'b0, ssag_pkg::OFS_IRQ_STAT, 32'h0);
        `CHK("chkEvent", 3'h3, rd[2:0])
        `CHK("irqMasked", 1'b0, irq)
        bus(1'b1, ssag_pkg::OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irqOn", 1'b1, irq)
        bus(1'b0, ssag_pkg::OFS_IRQ_MASK, 32'h0);
        `CHK("maskBack", 3'h1, rd[2:0])
        bus(1'b1, ssag_pkg::OFS_IRQ_STAT, 32'h3);
        repeat (2) @(posedge clk);
        `CHK("irqCleared", 1'b0, irq)
        cmdStrobe <= 1'b0;
        repeat (8) @(posedge clk);
        memCmd <= 1'b1;
        repeat (8) @(posedge clk);
        bus(1'b0, ssag_pkg::OFS_IRQ_STAT, 32'h0);
        `CHK("memCmdEvent", 3'h2, rd[2:0])
    endtask : irq_test

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        for (int i = 0; i < 4; i++)
            strap(i[1], i[0], i[0]);
        gate_test();
        swrst_test();
        dma_test(1'b0, 8'h02, 4);
        dma_test(1'b1, 8'h02, 12);
        dma_test(1'b1, 8'h00, 4);
        irq_test();
        print_verdict();
    end
endmodule : ssag_top_tb
